// File: verilog/mcp_pkg.sv
// Package for the motor chopper and PWM configuration block.
// Assumes one 100 MHz clock and an AXI4-Lite register port with 32-bit data.
package mcp_pkg;
   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [3:0] ADDR_REF = 4'h0;
   localparam logic [3:0] ADDR_PCR = 4'h4;
   localparam logic [3:0] ADDR_UPD = 4'h8;
   localparam logic [3:0] ADDR_STAT = 4'hc;
   localparam logic [7:0] REF_RESET = 8'h00;
   localparam logic [7:0] PCR_RESET = 8'h00;
   localparam logic [7:0] REPEAT_RESET = 8'h00;
   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int BEMF_BIT = 7;
   localparam int CURR_BIT = 6;
   localparam int INSEL_BIT = 5;
   localparam int CHOP_MODE_LO = 3;
   localparam int CHOP_FREQ_LO = 0;
   localparam int WIDTH_BIT = 7;
   localparam int FULL_U_BIT = 6;
   localparam int FULL_V_BIT = 5;
   localparam int FULL_W_BIT = 4;
   localparam int ALIGN_BIT = 3;
   localparam int PRESCALE_LO = 0;
   // ----------------------------------------------------------------------
   // Chopping modes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      MCP_CHOP_OFF = 2'h0,
      MCP_CHOP_LOW = 2'h1,
      MCP_CHOP_HIGH = 2'h2,
      MCP_CHOP_BOTH = 2'h3
   } mcp_chop_e;
   // ----------------------------------------------------------------------
   // Chopper timing: the base rates are those at a 4 MHz motor clock.
   // ----------------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int MTC_BASE_HZ = 4_000_000;
   localparam int CHOP_BASE_KHZ [8] = '{50, 100, 200, 250, 400, 500, 666, 1000};
   localparam int DIV_W = 16;
endpackage : mcp_pkg

// File: verilog/mcp_chopper.sv
// Chopper clock generator with a 50 percent duty square wave.
// Assumes freq_sel_i comes from a stored register field of the parent.
`timescale 1ns/1ns
module mcp_chopper #(
   parameter int MTC_HZ = 4_000_000
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [2:0] freq_sel_i,
   output logic chop_o
);
   // Half period in core clock cycles for each code, scaled by motor clock.
   function automatic logic [mcp_pkg::DIV_W-1:0] half_period(input logic [2:0] code);
      longint f;
      f = longint'(mcp_pkg::CHOP_BASE_KHZ[code]) * 1000 * MTC_HZ / mcp_pkg::MTC_BASE_HZ;
      if (code == 3'h6) begin
         f = 64'd2000000 * MTC_HZ / (3 * mcp_pkg::MTC_BASE_HZ);
      end
      half_period = mcp_pkg::DIV_W'(mcp_pkg::CLK_HZ / (2 * f));
   endfunction : half_period

   logic [mcp_pkg::DIV_W-1:0] count;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count <= '0;
         chop_o <= 1'b0;
      end else if (count + 1'b1 >= half_period(freq_sel_i)) begin
         count <= '0;
         chop_o <= ~chop_o;
      end else begin
         count <= count + 1'b1;
      end
   end
endmodule : mcp_chopper

// File: verilog/mcp_config.sv
// Configuration and status of the motor chopper and three-phase PWM counter.
// Assumes comparator levels synchronous to core_clk_i and an AXI4-Lite master.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// Summary of operation
// - Back-EMF comparator read at bit 7
// - Current comparator read at bit 6
// - Bit 5 picks current comparator input
// - Bits 4:3 decode chopping mode
// - Three bits select chopping frequency
// - Chopper has fifty percent duty
// - Width bit moves extension bit
// - Full-duty bit forces phase between updates
// - Full-duty bits clear after transfer
// - Bit 3 picks edge or center counting
// - Prescaler divides by code plus one, except code 7 which divides by 7
// - Both registers reset to zero
// - Update when repeat counter hits zero
module mcp_config #(
   parameter int MTC_HZ = 4_000_000
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic bemf_comparator_out_i,
   input wire logic current_comparator_out_i,
   input wire logic current_input_first_i,
   input wire logic current_amp_output_i,
   input wire logic pwm_period_end_i,
   output logic current_comparator_in_o,
   output logic chop_high_o,
   output logic chop_low_o,
   output logic compare_width_select_o,
   output logic [2:0] full_duty_o,
   output logic counter_alignment_select_o,
   output logic pwm_count_en_o,
   output logic update_o
);
   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [5:0] ref_cfg;
   logic [7:0] pcr;
   logic [7:0] repeat_value;
   logic [7:0] repeat_count;
   logic [2:0] full_active;
   logic [2:0] prescale_count;
   logic chop;
   logic [7:0] ref_read;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_held;
   logic w_held;
   logic do_write;
   logic update;
   logic [1:0] chop_mode;

   // Registers are decoded by word; the two low address bits are ignored.
   function automatic logic hit(input logic [3:0] a, input logic [3:0] t);
      hit = (a[3:2] == t[3:2]);
   endfunction : hit

   function automatic logic mapped(input logic [3:0] a);
      mapped = hit(a, mcp_pkg::ADDR_REF) || hit(a, mcp_pkg::ADDR_PCR) ||
               hit(a, mcp_pkg::ADDR_UPD) || hit(a, mcp_pkg::ADDR_STAT);
   endfunction : mapped

   // ----------------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------------
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign do_write = aw_held & w_held & ~s_axi_bvalid;

   // Per-register write strobes; byte lane 0 carries all eight bits.
   logic wr_ref;
   logic wr_pcr;
   logic wr_upd;
   assign wr_ref = do_write & w_strb[0] & hit(aw_addr, mcp_pkg::ADDR_REF);
   assign wr_pcr = do_write & w_strb[0] & hit(aw_addr, mcp_pkg::ADDR_PCR);
   assign wr_upd = do_write & w_strb[0] & hit(aw_addr, mcp_pkg::ADDR_UPD);

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Reference register: status bits are live, only bits 5:0 are stored
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ref_cfg <= mcp_pkg::REF_RESET[5:0];
      end else if (wr_ref) begin
         ref_cfg <= w_data[5:0];
      end
   end

   assign ref_read = {bemf_comparator_out_i, current_comparator_out_i, ref_cfg};

   // ----------------------------------------------------------------------
   // PWM control register; update clears full-duty bits, a write wins
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pcr <= mcp_pkg::PCR_RESET;
      end else if (wr_pcr) begin
         pcr <= w_data[7:0];
      end else if (update) begin
         pcr[mcp_pkg::FULL_U_BIT:mcp_pkg::FULL_W_BIT] <= 3'h0;
      end
   end

   // ----------------------------------------------------------------------
   // Repetition counter and update event
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         repeat_value <= mcp_pkg::REPEAT_RESET;
      end else if (wr_upd) begin
         repeat_value <= w_data[7:0];
      end
   end

   assign update = pwm_period_end_i && (repeat_count == 8'h00);

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         repeat_count <= mcp_pkg::REPEAT_RESET;
      end else if (update) begin
         repeat_count <= repeat_value;
      end else if (pwm_period_end_i) begin
         repeat_count <= repeat_count - 8'h01;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         full_active <= 3'h0;
         update_o <= 1'b0;
      end else begin
         update_o <= update;
         if (update) begin
            full_active <= pcr[mcp_pkg::FULL_U_BIT:mcp_pkg::FULL_W_BIT];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Prescaler: code N divides by N+1; code 7 divides by 7 like code 6
   // ----------------------------------------------------------------------
   logic [2:0] prescale_max;
   assign prescale_max = (pcr[2:0] == 3'h7) ? 3'h6 : pcr[2:0];

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prescale_count <= 3'h0;
      end else if (prescale_count >= prescale_max) begin
         prescale_count <= 3'h0;
      end else begin
         prescale_count <= prescale_count + 3'h1;
      end
   end

   assign pwm_count_en_o = (prescale_count >= prescale_max);

   // ----------------------------------------------------------------------
   // Chopper and outputs
   // ----------------------------------------------------------------------
   mcp_chopper #(
      .MTC_HZ(MTC_HZ)
   ) u_chopper (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .freq_sel_i(ref_cfg[2:0]),
      .chop_o(chop)
   );

   assign chop_mode = ref_cfg[4:3];

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         chop_high_o <= 1'b0;
         chop_low_o <= 1'b0;
      end else begin
         case (mcp_pkg::mcp_chop_e'(chop_mode))
            mcp_pkg::MCP_CHOP_LOW: begin
               chop_high_o <= 1'b0;
               chop_low_o <= chop;
            end
            mcp_pkg::MCP_CHOP_HIGH: begin
               chop_high_o <= chop;
               chop_low_o <= 1'b0;
            end
            mcp_pkg::MCP_CHOP_BOTH: begin
               chop_high_o <= chop;
               chop_low_o <= chop;
            end
            default: begin
               chop_high_o <= 1'b0;
               chop_low_o <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Current comparator input selection
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         current_comparator_in_o <= 1'b0;
      end else begin
         current_comparator_in_o <= ref_cfg[mcp_pkg::INSEL_BIT] ?
                                    current_input_first_i : current_amp_output_i;
      end
   end

   assign compare_width_select_o = pcr[mcp_pkg::WIDTH_BIT];
   assign full_duty_o = full_active;
   assign counter_alignment_select_o = pcr[mcp_pkg::ALIGN_BIT];

   // ----------------------------------------------------------------------
   // Read data selection
   // ----------------------------------------------------------------------
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0;
      if (hit(s_axi_araddr, mcp_pkg::ADDR_REF)) begin
         next_rdata = {24'h0, ref_read};
      end else if (hit(s_axi_araddr, mcp_pkg::ADDR_PCR)) begin
         next_rdata = {24'h0, pcr};
      end else if (hit(s_axi_araddr, mcp_pkg::ADDR_UPD)) begin
         next_rdata = {24'h0, repeat_value};
      end else if (hit(s_axi_araddr, mcp_pkg::ADDR_STAT)) begin
         next_rdata = {21'h0, full_active, repeat_count};
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
         s_axi_rdata <= next_rdata;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : mcp_config

// File: testbench/mcp_config_asserts.sv
// Checker for the configuration block, bound to its ports.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ns
module mcp_config_chk (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic bemf_comparator_out_i,
   input wire logic current_comparator_out_i,
   input wire logic pwm_period_end_i,
   input wire logic [2:0] full_duty_o,
   input wire logic pwm_count_en_o,
   input wire logic update_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   chk_bemf_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0
      |=> s_axi_rdata[7] == $past(bemf_comparator_out_i)) else $error("bemf bit wrong");
   chk_curr_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0
      |=> s_axi_rdata[6] == $past(current_comparator_out_i)) else $error("current bit wrong");
   chk_full_cause: assert property ($changed(full_duty_o) |-> $past(pwm_period_end_i))
      else $error("full duty changed without period end");
   chk_update_cause: assert property (update_o |-> $past(pwm_period_end_i))
      else $error("update without period end");
   chk_update_pulse: assert property (update_o |=> !update_o)
      else $error("update longer than one cycle");
   chk_count_gap: assert property (pwm_count_en_o |=> ##[0:6] pwm_count_en_o)
      else $error("prescaler gap too long");
   chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during response");
   chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not ended after handshake");
   chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response not ended after handshake");
endmodule : mcp_config_chk
bind mcp_config mcp_config_chk i_mcp_config_chk (.*);

// File: testbench/mcp_power_stage.sv
// Model of the inverter stage: comparator levels and period-end pulses.
// Assumes the bench sets the wanted levels one cycle ahead.
`timescale 1ns/1ns
module mcp_power_stage (
   input wire logic core_clk_i,
   input wire logic [4:0] stim_i,
   output logic [4:0] stage_o
);
   // Levels reach the block one clock after they are asked for.
   initial stage_o = 5'h00;
   always @(posedge core_clk_i) stage_o <= stim_i;
endmodule : mcp_power_stage

// File: testbench/tb_mcp_config.sv
// Self-checking bench for the configuration block over AXI4-Lite.
// Assumes the power stage model feeds comparator levels and period ends.
`timescale 1ns/1ns
module tb_mcp_config;
   logic core_clk_i, reset_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_b;
   logic bemf_comparator_out_i, current_comparator_out_i, current_input_first_i;
   logic current_amp_output_i, pwm_period_end_i, current_comparator_in_o, chop_high_o;
   logic chop_low_o, compare_width_select_o, counter_alignment_select_o, pwm_count_en_o;
   logic update_o, hs, ls;
   logic [2:0] full_duty_o;
   logic [4:0] stim;
   int errors, comparisons, hi, lo, n;
   mcp_config i_mcp_config (.*);
   mcp_power_stage i_mcp_power_stage (.core_clk_i(core_clk_i), .stim_i(stim),
      .stage_o({bemf_comparator_out_i, current_comparator_out_i, current_input_first_i,
      current_amp_output_i, pwm_period_end_i}));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // ----------------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic aw, w;
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w) begin
         @(posedge core_clk_i);
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge core_clk_i); while (s_axi_bvalid !== 1'b1);
      wr_b = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk_i); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk_i); while (s_axi_rvalid !== 1'b1);
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic pulse();
      stim[0] <= 1'b1;
      @(posedge core_clk_i);
      stim[0] <= 1'b0;
      n = 0;
      repeat (6) @(posedge core_clk_i) n += int'(update_o);
   endtask : pulse
   task end_sim;
      if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   initial begin
      #800_000;
      errors++;
      end_sim;
   end
   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
      stim = 5'h00;
      reset_i = 1'b1;
      repeat (16) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd(mcp_pkg::ADDR_REF);
      chk(rd_d, 32'h0);
      rd(mcp_pkg::ADDR_PCR);
      chk(rd_d, 32'h0);
      stim <= 5'h10;
      wr(mcp_pkg::ADDR_REF, 32'hff);
      chk(32'(wr_b), 32'h0);
      rd(mcp_pkg::ADDR_REF);
      chk(rd_d, 32'hbf);
      stim <= 5'h08;
      repeat (3) @(posedge core_clk_i);
      rd(mcp_pkg::ADDR_REF);
      chk(rd_d, 32'h7f);
      stim <= 5'h04;
      repeat (4) @(posedge core_clk_i);
      chk(32'(current_comparator_in_o), 32'h1);
      wr(mcp_pkg::ADDR_REF, 32'h1f);
      repeat (4) @(posedge core_clk_i);
      chk(32'(current_comparator_in_o), 32'h0);
      stim <= 5'h02;
      repeat (4) @(posedge core_clk_i);
      chk(32'(current_comparator_in_o), 32'h1);
      for (int m = 0; m < 4; m++) begin
         wr(mcp_pkg::ADDR_REF, 32'(m * 8 + 7));
         hs = 1'b0;
         ls = 1'b0;
         repeat (200) @(posedge core_clk_i) {hs, ls} = {hs | chop_high_o, ls | chop_low_o};
         chk(32'({hs, ls}), 32'(m));
      end
      for (int c = 0; c < 8; c++) begin
         wr(mcp_pkg::ADDR_REF, 32'(8 + c));
         do @(posedge core_clk_i); while (chop_low_o !== 1'b0);
         do @(posedge core_clk_i); while (chop_low_o !== 1'b1);
         hi = 0;
         lo = 0;
         do begin @(posedge core_clk_i); hi++; end while (chop_low_o === 1'b1);
         do begin @(posedge core_clk_i); lo++; end while (chop_low_o === 1'b0);
         chk(32'(hi), 32'(50000 / mcp_pkg::CHOP_BASE_KHZ[c]));
         chk(32'(lo), 32'(hi));
      end
      wr(mcp_pkg::ADDR_PCR, 32'h88);
      chk(32'(compare_width_select_o), 32'h1);
      chk(32'(counter_alignment_select_o), 32'h1);
      wr(mcp_pkg::ADDR_PCR, 32'h0, 4'he);
      rd(mcp_pkg::ADDR_PCR);
      chk(rd_d, 32'h88);
      wr(mcp_pkg::ADDR_UPD, 32'h1);
      wr(mcp_pkg::ADDR_PCR, 32'h50);
      chk(32'({compare_width_select_o, counter_alignment_select_o}), 32'h0);
      pulse();
      chk(32'(n), 32'h1);
      chk(32'(full_duty_o), 32'h5);
      rd(mcp_pkg::ADDR_PCR);
      chk(rd_d, 32'h0);
      wr(mcp_pkg::ADDR_PCR, 32'h20);
      pulse();
      chk(32'(n), 32'h0);
      chk(32'(full_duty_o), 32'h5);
      pulse();
      chk(32'(full_duty_o), 32'h2);
      rd(mcp_pkg::ADDR_STAT);
      chk(rd_d, 32'h201);
      // Byte address 2 lies in the reference word; comparators both low here.
      rd(4'h2);
      chk(32'(rd_r), 32'h0);
      chk(rd_d, 32'h0f);
      for (int c = 0; c < 8; c++) begin
         wr(mcp_pkg::ADDR_PCR, 32'(c));
         do @(posedge core_clk_i); while (pwm_count_en_o !== 1'b1);
         n = 0;
         do begin @(posedge core_clk_i); n++; end while (pwm_count_en_o !== 1'b1);
         chk(32'(n), (c == 7) ? 32'h7 : 32'(c + 1));
      end
      end_sim;
   end
endmodule : tb_mcp_config
